//--- fcbu_pkg.sv
// fcbu_pkg: constants and types for the fp condition branch unit
// assumes a 32-bit instruction word and 32-bit program counter
package fcbu_pkg;

	// instruction fields
	localparam int          REG_W      = 32;
	localparam logic [5:0]  FP_COP_OPC = 6'h11;
	localparam logic [4:0]  BR_COND_FM = 5'h08;
	localparam int          OPC_HI     = 31;
	localparam int          OPC_LO     = 26;
	localparam int          FMT_HI     = 25;
	localparam int          FMT_LO     = 21;
	localparam int          SEL_HI     = 20;
	localparam int          SEL_LO     = 18;
	localparam int          NUL_BIT    = 17;
	localparam int          POL_BIT    = 16;
	localparam int          OFF_W      = 16;
	localparam int          OFF_SHIFT  = 2;
	localparam logic [31:0] SLOT_STEP  = 32'h0000_0004;
	localparam int          CC_NUM     = 8;
	localparam int          CC_SEL_W   = 3;

	// register map (word index on the plain port)
	localparam int          ADDR_W     = 4;
	localparam logic [3:0]  ADDR_CTRL  = 4'h0;
	localparam logic [3:0]  ADDR_STAT  = 4'h1;
	localparam logic [3:0]  ADDR_MASK  = 4'h2;
	localparam logic [3:0]  ADDR_COUNT = 4'h3;
	localparam logic [3:0]  ADDR_TGT   = 4'h4;
	localparam logic [3:0]  ADDR_COND  = 4'h5;

	// control fields and reset values
	localparam int          CTRL_CU1   = 0;
	localparam int          CTRL_FPU   = 1;
	localparam logic [1:0]  CTRL_RST   = 2'h3;
	localparam logic [4:0]  MASK_RST   = 5'h00;
	localparam logic [7:0]  COND_RST   = 8'h00;
	localparam int          CNT_W      = 16;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SLOT = 2'b10
	} fcbu_state_type;

	// sticky events, bit 0 is taken
	typedef struct packed {
		logic unimp;
		logic resv;
		logic cpu;
		logic nul;
		logic taken;
	} fcbu_ev_type;

	typedef struct packed {
		logic                is_fpbr;
		logic [CC_SEL_W-1:0] cond_selector;
		logic                nullify_flag;
		logic                polarity_bit;
		logic [REG_W-1:0]    target;
	} fcbu_dec_type;

endpackage : fcbu_pkg

//--- fcbu_decode.sv
// fcbu_decode: recognises the fp condition branch and forms its target
// assumes instr and branch_pc are stable in the cycle they are offered
`timescale 1ns/10ps
`default_nettype none
module fcbu_decode (
	// instruction in
	input  wire logic [31:0]               instr,
	input  wire logic [31:0]               branch_pc,
	// decoded out
	output fcbu_pkg::fcbu_dec_type         dec
);
	import fcbu_pkg::*;

	wire logic [REG_W-1:0] offs_ext;
	wire logic [REG_W-1:0] slot_pc;

	assign dec.is_fpbr = (instr[OPC_HI:OPC_LO] == FP_COP_OPC)
		&& (instr[FMT_HI:FMT_LO] == BR_COND_FM);
	assign dec.cond_selector = instr[SEL_HI:SEL_LO];
	assign dec.nullify_flag  = instr[NUL_BIT];
	assign dec.polarity_bit  = instr[POL_BIT];
	// offset of the delay slot, not of the branch itself
	assign offs_ext = {{(REG_W-OFF_W-OFF_SHIFT){instr[OFF_W-1]}},
		instr[OFF_W-1:0], {OFF_SHIFT{1'b0}}};
	assign slot_pc    = branch_pc + SLOT_STEP;
	assign dec.target = slot_pc + offs_ext;

endmodule : fcbu_decode
`default_nettype wire

//--- fcbu_cond_store.sv
// fcbu_cond_store: the eight fp condition code bits
// assumes the fp compare writes one bit per cycle via wr/idx/val
`timescale 1ns/10ps
`default_nettype none
module fcbu_cond_store (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// compare write
	input  wire logic                          wr,
	input  wire logic [fcbu_pkg::CC_SEL_W-1:0] idx,
	input  wire logic                          val,
	// branch read
	input  wire logic [fcbu_pkg::CC_SEL_W-1:0] sel,
	output logic                               sel_bit,
	output logic [fcbu_pkg::CC_NUM-1:0]        bits
);
	import fcbu_pkg::*;

	logic [CC_NUM-1:0] cc_ff;
	logic [CC_NUM-1:0] nxt_cc;

	// no bypass: a branch right behind its compare sees the old bit
	always_comb begin
		nxt_cc = cc_ff;
		if (wr) begin
			nxt_cc[idx] = val;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cc_ff <= COND_RST;
		end else begin
			cc_ff <= nxt_cc;
		end
	end

	assign sel_bit = cc_ff[sel];
	assign bits    = cc_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	cc_write_a: assert property (wr |=> cc_ff[$past(idx)] == $past(val))
		else $error("compare write did not land in cond bit");
	cc_keep_a: assert property (!wr |=> cc_ff == $past(cc_ff))
		else $error("cond bits changed without a compare");
	sel_read_a: assert property (sel_bit == cc_ff[sel])
		else $error("selected cond bit mismatch");

endmodule : fcbu_cond_store
`default_nettype wire

//--- fcbu_branch_unit.sv
// fcbu_branch_unit: executes the four fp condition branch variants
// assumes pipeline offers one instruction per instr_valid and flags
// slot_valid when the delay-slot instruction reaches execute
`timescale 1ns/10ps
`default_nettype none
module fcbu_branch_unit (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// pipeline
	input  wire logic                          instr_valid,
	input  wire logic [31:0]                   instr,
	input  wire logic [31:0]                   instr_pc,
	input  wire logic                          slot_valid,
	// fp coprocessor
	input  wire logic                          fcmp_wr,
	input  wire logic [fcbu_pkg::CC_SEL_W-1:0] fcmp_idx,
	input  wire logic                          fcmp_val,
	input  wire logic                          fpu_unimpl,
	// redirect and nullify
	output logic                               pc_load_ff,
	output logic [fcbu_pkg::REG_W-1:0]         pc_target_ff,
	output logic                               slot_nullify_ff,
	// exceptions
	output logic                               exc_cpu_ff,
	output logic                               exc_resv_ff,
	output logic                               exc_unimp_ff,
	// register port
	input  wire logic [fcbu_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic [31:0]                        reg_rdata_ff,
	// interrupt
	output logic                               irq_ff
);
	import fcbu_pkg::*;

	fcbu_dec_type      dec;
	fcbu_ev_type       stat_ff;
	fcbu_ev_type       nxt_stat;
	fcbu_ev_type       ev;
	fcbu_state_type    state_ff;
	fcbu_state_type    nxt_state;
	logic [4:0]        mask_ff;
	logic [1:0]        ctrl_ff;
	logic [CNT_W-1:0]  count_ff;
	logic              taken_ff;
	logic              cc_bit;
	logic [CC_NUM-1:0] cc_bits;
	logic [31:0]       rd_mux;

	fcbu_decode u_decode (
		.instr     (instr),
		.branch_pc (instr_pc),
		.dec       (dec)
	);

	fcbu_cond_store u_cond (
		.clk     (clk),
		.rst     (rst),
		.wr      (fcmp_wr),
		.idx     (fcmp_idx),
		.val     (fcmp_val),
		.sel     (dec.cond_selector),
		.sel_bit (cc_bit),
		.bits    (cc_bits)
	);

	// a branch sitting in our own delay slot is ignored
	wire logic offered   = instr_valid && dec.is_fpbr && (state_ff == ST_IDLE);
	wire logic cu1_off   = !ctrl_ff[CTRL_CU1];
	wire logic fpu_off   = !ctrl_ff[CTRL_FPU];
	wire logic raise_cpu = offered && cu1_off;
	wire logic raise_ri  = offered && !cu1_off && fpu_off;
	wire logic raise_un  = offered && !cu1_off && !fpu_off && fpu_unimpl;
	wire logic accept    = offered && !cu1_off && !fpu_off && !fpu_unimpl;
	wire logic cond_met  = dec.polarity_bit ? cc_bit : !cc_bit;
	wire logic nul_next  = accept && dec.nullify_flag && !cond_met;
	wire logic slot_done = (state_ff == ST_SLOT) && slot_valid;
	wire logic wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL);
	wire logic wr_mask   = reg_wr && (reg_addr == ADDR_MASK);
	wire logic rd_stat   = reg_rd && (reg_addr == ADDR_STAT);

	// state: wait for the delay slot before redirecting
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_state = ST_SLOT;
				end
			end
			ST_SLOT: begin
				if (slot_valid) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// condition and target are frozen when the branch executes
	always_ff @(posedge clk) begin
		if (rst) begin
			taken_ff     <= 1'b0;
			pc_target_ff <= 32'h0000_0000;
		end else if (accept) begin
			taken_ff     <= cond_met;
			pc_target_ff <= dec.target;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pc_load_ff <= 1'b0;
		end else begin
			pc_load_ff <= slot_done && taken_ff;
		end
	end

	// nullify stands from the branch until the slot shows up
	always_ff @(posedge clk) begin
		if (rst) begin
			slot_nullify_ff <= 1'b0;
		end else if (accept) begin
			slot_nullify_ff <= nul_next;
		end else if (slot_done) begin
			slot_nullify_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			exc_cpu_ff   <= 1'b0;
			exc_resv_ff  <= 1'b0;
			exc_unimp_ff <= 1'b0;
		end else begin
			exc_cpu_ff   <= raise_cpu;
			exc_resv_ff  <= raise_ri;
			exc_unimp_ff <= raise_un;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= '0;
		end else if (slot_done && taken_ff) begin
			count_ff <= count_ff + 16'h0001;
		end
	end

	// sticky status; a new event wins over the clearing read
	assign ev.taken = slot_done && taken_ff;
	assign ev.nul   = nul_next;
	assign ev.cpu   = raise_cpu;
	assign ev.resv  = raise_ri;
	assign ev.unimp = raise_un;
	assign nxt_stat = (rd_stat ? fcbu_ev_type'(5'h00) : stat_ff) | ev;

	always_ff @(posedge clk) begin
		if (rst) begin
			stat_ff <= fcbu_ev_type'(5'h00);
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RST;
			mask_ff <= MASK_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= reg_wdata[1:0];
			end
			if (wr_mask) begin
				mask_ff <= reg_wdata[4:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_stat & mask_ff);
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		if (reg_addr == ADDR_CTRL) begin
			rd_mux = {30'h0000_0000, ctrl_ff};
		end else if (reg_addr == ADDR_STAT) begin
			rd_mux = {27'h000_0000, stat_ff};
		end else if (reg_addr == ADDR_MASK) begin
			rd_mux = {27'h000_0000, mask_ff};
		end else if (reg_addr == ADDR_COUNT) begin
			rd_mux = {16'h0000, count_ff};
		end else if (reg_addr == ADDR_TGT) begin
			rd_mux = pc_target_ff;
		end else if (reg_addr == ADDR_COND) begin
			rd_mux = {24'h00_0000, cc_bits};
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_ff <= 32'h0000_0000;
		end else begin
			reg_rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	decode_fmt_a: assert property (dec.is_fpbr |-> instr[31:21] == 11'h228)
		else $error("branch recognised with wrong opcode or format");
	target_calc_a: assert property (accept |=> pc_target_ff ==
		$past(instr_pc) + 32'h0000_0004
		+ {{14{$past(instr[15])}}, $past(instr[15:0]), 2'b00})
		else $error("branch target wrong");
	false_pol_a: assert property (accept && !dec.polarity_bit
		|=> taken_ff == !$past(cc_bit))
		else $error("false polarity evaluated wrong");
	true_pol_a: assert property (accept && dec.polarity_bit
		|=> taken_ff == $past(cc_bit))
		else $error("true polarity evaluated wrong");
	pc_after_slot_a: assert property (pc_load_ff |->
		$past(slot_valid) && $past(state_ff) == ST_SLOT && $past(taken_ff))
		else $error("pc loaded before the delay slot");
	no_early_load_a: assert property (accept |=> !pc_load_ff)
		else $error("pc loaded in the branch cycle");
	nul_likely_a: assert property (accept && dec.nullify_flag && !cond_met
		|=> slot_nullify_ff throughout (state_ff == ST_SLOT))
		else $error("likely slot not nullified");
	nul_plain_a: assert property (accept && (!dec.nullify_flag || cond_met)
		|=> !slot_nullify_ff)
		else $error("slot nullified wrongly");
	cpu_exc_a: assert property (instr_valid && dec.is_fpbr && state_ff == ST_IDLE
		&& !ctrl_ff[CTRL_CU1] |=> exc_cpu_ff && state_ff == ST_IDLE)
		else $error("unusable exception missing or branch taken");
	unimp_exc_a: assert property (raise_un |=> exc_unimp_ff ##1 !pc_load_ff)
		else $error("unimplemented exception missing");
	slot_branch_a: assert property (state_ff == ST_SLOT && !slot_valid
		|=> state_ff == ST_SLOT && $stable(pc_target_ff))
		else $error("delay slot branch disturbed state");

	likely_taken_c: cover property (accept && dec.nullify_flag && cond_met
		##[1:8] pc_load_ff);
	likely_null_c: cover property (accept && dec.nullify_flag && !cond_met);
	plain_taken_c: cover property (accept && !dec.nullify_flag ##[1:8] pc_load_ff);
	exc_c: cover property (exc_cpu_ff || exc_resv_ff || exc_unimp_ff);

endmodule : fcbu_branch_unit
`default_nettype wire

//--- fcbu_pipe_model.sv
// fcbu_pipe_model: pipeline and fp compare side of the branch unit
// assumes the bench calls one task at a time
`timescale 1ns/10ps
`default_nettype none
module fcbu_pipe_model (
	// clock
	input  wire logic        clk,
	// to the unit
	output logic             instr_valid,
	output logic [31:0]      instr,
	output logic [31:0]      instr_pc,
	output logic             slot_valid,
	output logic             fcmp_wr,
	output logic [2:0]       fcmp_idx,
	output logic             fcmp_val,
	output logic             fpu_unimpl,
	// from the unit
	input  wire logic        pc_load_ff,
	input  wire logic        slot_nullify_ff,
	input  wire logic [2:0]  exc
);
	initial begin
		instr_valid = 1'b0;
		instr = 32'h0000_0000;
		instr_pc = 32'h0000_0000;
		slot_valid = 1'b0;
		fcmp_wr = 1'b0;
		fcmp_idx = 3'h0;
		fcmp_val = 1'b0;
		fpu_unimpl = 1'b0;
	end

	// one compare result written per call
	task automatic set_cc(input logic [2:0] i, input logic v);
		@(posedge clk);
		fcmp_wr <= 1'b1;
		fcmp_idx <= i;
		fcmp_val <= v;
		@(posedge clk);
		fcmp_wr <= 1'b0;
		fcmp_val <= ~v;
	endtask : set_cc

	// slot follows the branch after gap+1 idle cycles; stale instr and fpu_unimpl inverted, instr_pc left as is
	task automatic branch(input logic [31:0] w, input logic [31:0] pc, input logic u,
		input int gap, output logic nul, output logic ld, output logic early,
		output logic [2:0] ex);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= w;
		instr_pc <= pc;
		fpu_unimpl <= u;
		@(posedge clk);
		instr_valid <= 1'b0;
		instr <= ~w;
		fpu_unimpl <= ~u;
		#1;
		nul = slot_nullify_ff;
		ex = exc;
		early = pc_load_ff;
		repeat (gap) begin
			@(posedge clk);
			#1;
			early = early | pc_load_ff;
		end
		@(posedge clk);
		slot_valid <= 1'b1;
		@(posedge clk);
		slot_valid <= 1'b0;
		#1;
		ld = pc_load_ff;
	endtask : branch
endmodule : fcbu_pipe_model
`default_nettype wire

//--- tb_fcbu_branch_unit.sv
// tb_fcbu_branch_unit: self-checking bench for the fp branch unit
// assumes mask bit set means the event may raise the interrupt
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_fcbu_branch_unit;
	import fcbu_pkg::*;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               instr_valid, slot_valid, fcmp_wr, fcmp_val, fpu_unimpl;
	logic [31:0]        instr, instr_pc, pc_target_ff, reg_wdata, reg_rdata_ff;
	logic [2:0]         fcmp_idx;
	logic               pc_load_ff, slot_nullify_ff, irq_ff;
	logic               exc_cpu_ff, exc_resv_ff, exc_unimp_ff;
	logic [ADDR_W-1:0]  reg_addr;
	logic               reg_wr, reg_rd;
	logic               nul, ld, early;
	logic [2:0]         ex;
	int                 fails = 0;
	int                 cmp_count = 0;
	int                 cycles = 0;

	always #25 clk = ~clk;

	fcbu_branch_unit u_fcbu_branch_unit (.clk(clk), .rst(rst), .instr_valid(instr_valid),
		.instr(instr), .instr_pc(instr_pc), .slot_valid(slot_valid), .fcmp_wr(fcmp_wr),
		.fcmp_idx(fcmp_idx), .fcmp_val(fcmp_val), .fpu_unimpl(fpu_unimpl),
		.pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff),
		.slot_nullify_ff(slot_nullify_ff), .exc_cpu_ff(exc_cpu_ff),
		.exc_resv_ff(exc_resv_ff), .exc_unimp_ff(exc_unimp_ff), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_ff(reg_rdata_ff), .irq_ff(irq_ff));

	fcbu_pipe_model u_fcbu_pipe_model (.clk(clk), .instr_valid(instr_valid),
		.instr(instr), .instr_pc(instr_pc), .slot_valid(slot_valid), .fcmp_wr(fcmp_wr),
		.fcmp_idx(fcmp_idx), .fcmp_val(fcmp_val), .fpu_unimpl(fpu_unimpl),
		.pc_load_ff(pc_load_ff), .slot_nullify_ff(slot_nullify_ff),
		.exc({exc_cpu_ff, exc_resv_ff, exc_unimp_ff}));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// run is about 150 cycles; this only catches a hang
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(n, e, reg_rdata_ff)
	endtask : reg_chk

	task automatic irq_chk(input logic e);
		@(posedge clk);
		#1;
		`CHK("irq", e, irq_ff)
	endtask : irq_chk

	task automatic t_reset();
		reg_write(4'hf, 32'hffff_ffff);
		reg_chk(ADDR_CTRL, 32'h0000_0003, "ctrl");
		reg_chk(ADDR_STAT, 32'h0000_0000, "status");
		reg_chk(ADDR_MASK, 32'h0000_0000, "mask");
		reg_chk(ADDR_COUNT, 32'h0000_0000, "count");
		reg_chk(ADDR_COND, 32'h0000_0000, "cond");
		reg_chk(4'hf, 32'h0000_0000, "unmapped");
		$display("test reset done");
	endtask : t_reset

	task automatic t_variants();
		logic [15:0] off;
		logic [31:0] w, pc, tgt;
		logic        tk;
		for (int k = 0; k < 8; k++) begin
			off = k[0] ? 16'h8001 : 16'h7fff;
			pc = 32'h1000_0000 + 32'(k * 64);
			w = {FP_COP_OPC, BR_COND_FM, 3'(k), k[2], k[1], off};
			tk = (k[1] == k[0]);
			tgt = pc + 32'h0000_0004 + {{14{off[15]}}, off, 2'b00};
			u_fcbu_pipe_model.set_cc(3'(k), k[0]);
			u_fcbu_pipe_model.branch(w, pc, 1'b0, k % 3, nul, ld, early, ex);
			`CHK("nullify", k[2] & ~tk, nul)
			`CHK("load", tk, ld)
			`CHK("early load", 1'b0, early)
			if (tk) `CHK("target", tgt, pc_target_ff)
		end
		reg_chk(ADDR_COND, 32'h0000_00aa, "cond bits");
		reg_chk(ADDR_COUNT, 32'h0000_0004, "taken count");
		reg_chk(ADDR_STAT, 32'h0000_0003, "status");
		reg_chk(ADDR_STAT, 32'h0000_0000, "status cleared");
		$display("test variants done");
	endtask : t_variants

	task automatic t_decode();
		logic [31:0] w [2];
		w[0] = {FP_COP_OPC, 5'h09, 21'h02_0000};
		w[1] = {6'h12, BR_COND_FM, 21'h02_0000};
		for (int i = 0; i < 2; i++) begin
			u_fcbu_pipe_model.branch(w[i], 32'h2000_0000, 1'b0, 1, nul, ld, early, ex);
			`CHK("foreign load", 1'b0, ld)
			`CHK("foreign exc", 3'b000, ex)
		end
		reg_chk(ADDR_COUNT, 32'h0000_0004, "count kept");
		$display("test decode done");
	endtask : t_decode

	task automatic t_except();
		logic [1:0]  ctl [3];
		logic [31:0] w;
		ctl = '{2'h2, 2'h1, 2'h3};
		w = {FP_COP_OPC, BR_COND_FM, 3'h1, 1'b0, 1'b1, 16'h0010};
		reg_write(ADDR_MASK, 32'h0000_001c);
		for (int i = 0; i < 3; i++) begin
			reg_write(ADDR_CTRL, {30'h0, ctl[i]});
			u_fcbu_pipe_model.branch(w, 32'h3000_0000, i == 2, 1, nul, ld, early, ex);
			`CHK("exception", 3'(3'b100 >> i), ex)
			`CHK("exc load", 1'b0, ld)
			irq_chk(1'b1);
			reg_chk(ADDR_STAT, 32'h0000_0004 << i, "exc status");
			irq_chk(1'b0);
		end
		reg_write(ADDR_CTRL, 32'h0000_0003);
		$display("test exceptions done");
	endtask : t_except

	task automatic t_irq();
		logic [31:0] w;
		w = {FP_COP_OPC, BR_COND_FM, 3'h1, 1'b1, 1'b1, 16'hfff0};
		reg_write(ADDR_MASK, 32'h0000_0000);
		u_fcbu_pipe_model.branch(w, 32'h4000_0000, 1'b0, 0, nul, ld, early, ex);
		`CHK("likely taken", 1'b1, ld)
		irq_chk(1'b0);
		reg_write(ADDR_MASK, 32'h0000_0001);
		irq_chk(1'b1);
		reg_chk(ADDR_TGT, 32'h3fff_ffc4, "last target");
		reg_chk(ADDR_STAT, 32'h0000_0001, "taken status");
		irq_chk(1'b0);
		$display("test interrupt done");
	endtask : t_irq

	initial begin
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_variants();
		t_decode();
		t_except();
		t_irq();
		report_and_stop();
	end
endmodule : tb_fcbu_branch_unit
`default_nettype wire
